// ### acc_regs.vh
`ifndef AAL_REGS_VH
`define AAL_REGS_VH
// Register byte addresses on APB
`define AAL_CTRL_ADDR     12'h000
`define AAL_OPND_ADDR     12'h004
`define AAL_ACCU_ADDR     12'h008
`define AAL_STAT_ADDR     12'h00C
// Data memory window: page select in address bits 11:8
`define AAL_MEM_PAGE      4'h1
// Memory depth
`define AAL_MEM_WORDS     64
`define AAL_MEM_AW        6
// Opcode field in control write data
`define AAL_OP_LSB        0
`define AAL_OP_MSB        1
`define AAL_OP_ADD_MEM    2'h0
`define AAL_OP_AND_ACC    2'h1
`define AAL_OP_AND_IMM    2'h2
`define AAL_OP_AND_MEM    2'h3
// Operand register fields
`define AAL_IMM_LSB       0
`define AAL_IMM_MSB       7
`define AAL_IDX_LSB       8
`define AAL_IDX_MSB       13
// Flag bit positions in status
`define AAL_F_CARRY       0
`define AAL_F_AUXC        1
`define AAL_F_ZERO        2
`define AAL_F_OVFL        3
`define AAL_F_SCARRY      4
// Reset values
`define AAL_ACCU_RST      8'h00
`define AAL_FLAGS_RST     5'h00
`define AAL_IMM_RST       8'h00
`define AAL_IDX_RST       6'h00
`define AAL_RDATA_RST     32'h0000_0000
`endif

// ### acc_alu.v
// Functional notes
// RULE1: Add-to-memory writes sum, updates five flags
// RULE2: AND memory into accumulator, zero only
// RULE3: AND immediate into accumulator, zero only
// RULE4: AND accumulator into memory location
// RULE5: Zero flag from result; others kept
//
// Accumulator slice with a small byte memory, reached over APB.
// Software loads the accumulator and a memory byte, then writes the
// operand register (immediate and memory index), then writes an
// opcode to the control register. The operation runs on the very
// edge at which that control write completes; there is no busy time.
//
// Register map (byte addresses, one aligned word each):
//   control   write-only, opcode in bits 1:0, reads as zero
//   operand   immediate in bits 7:0, memory index in bits 13:8
//   accum     read and write, value in bits 7:0
//   status    read-only, flags in bits 4:0
//   memory    64 bytes in the page above the registers
//
// Hazards a user must know:
//   - memory bytes are not reset; read one only after writing it
//   - the operand register must be written before the opcode;
//     a stale index makes the operation hit the old byte
//   - an unmapped address answers with an error and is ignored
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.vh"
module aal_alu (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave request
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    // APB slave answer
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Core state
    output wire [7:0]  accumulator,
    output reg  [4:0]  flags_q
);
    // Architectural state
    reg  [7:0]             accum_q;
    reg  [7:0]             accum_d;
    reg  [4:0]             flags_d;
    reg  [7:0]             imm_q;
    reg  [7:0]             imm_d;
    reg  [`AAL_MEM_AW-1:0] idx_q;
    reg  [`AAL_MEM_AW-1:0] idx_d;
    reg  [7:0]             mem_q [0:`AAL_MEM_WORDS-1];
    // Bus answer registers
    reg  [31:0]            prdata_q;
    reg  [31:0]            prdata_d;
    reg                    pready_q;
    reg                    pslverr_q;
    // Transfer phases
    wire                   setup;
    wire                   access;
    wire                   wr_done;
    wire                   rd_setup;
    // Address decode
    wire                   hit_ctrl;
    wire                   hit_opnd;
    wire                   hit_accu;
    wire                   hit_stat;
    wire                   hit_mem;
    wire                   mapped;
    wire [`AAL_MEM_AW-1:0] mem_idx;
    // Operation datapath
    wire                   go;
    wire [1:0]             op;
    wire [7:0]             mval;
    wire [8:0]             sum;
    wire [4:0]             lo_sum;
    wire                   ovfl;
    wire                   scarry;
    wire [7:0]             and_mem;
    wire [7:0]             and_imm;
    wire                   mem_wb;
    reg  [7:0]             res;

    // Phases of one transfer: setup, then the single access cycle
    assign setup    = psel & ~penable;
    assign access   = psel & penable & pready_q;
    assign wr_done  = access & pwrite;
    assign rd_setup = setup & ~pwrite;

    // Fixed registers and the memory page
    assign hit_ctrl = (paddr == `AAL_CTRL_ADDR);
    assign hit_opnd = (paddr == `AAL_OPND_ADDR);
    assign hit_accu = (paddr == `AAL_ACCU_ADDR);
    assign hit_stat = (paddr == `AAL_STAT_ADDR);
    assign hit_mem  = (paddr[11:8] == `AAL_MEM_PAGE);
    assign mem_idx  = paddr[7:2];
    assign mapped   = hit_ctrl | hit_opnd | hit_accu | hit_stat | hit_mem;

    // Opcode strobe: a completed write to the control register
    assign go       = wr_done & hit_ctrl;
    assign op       = pwdata[`AAL_OP_MSB:`AAL_OP_LSB];
    assign mval     = mem_q[idx_q];

    // Adder: nine bits for carry, five-bit low half for auxiliary carry
    assign sum      = {1'b0, accum_q} + {1'b0, mval};
    assign lo_sum   = {1'b0, accum_q[3:0]} + {1'b0, mval[3:0]};
    // Signed overflow: like-signed operands, result sign differs
    assign ovfl     = (accum_q[7] == mval[7]) & (sum[7] != accum_q[7]);
    // Signed carry is the true sign of the nine-bit signed sum
    assign scarry   = ovfl ^ sum[7];
    // Bitwise AND against memory byte or immediate
    assign and_mem  = accum_q & mval;
    assign and_imm  = accum_q & imm_q;

    // Result selection per operation
    always @* begin
        case (op)
            `AAL_OP_ADD_MEM: res = sum[7:0];
            `AAL_OP_AND_ACC: res = and_mem;
            `AAL_OP_AND_IMM: res = and_imm;
            default:         res = and_mem;
        endcase
    end

    // Memory is the destination of add and AND-to-memory
    assign mem_wb   = go & ((op == `AAL_OP_ADD_MEM) | (op == `AAL_OP_AND_MEM));

    // Next accumulator: operation wins over a bus load
    always @* begin
        accum_d = accum_q;
        if (go) begin
            case (op)
                // RULE2: AND memory in
                `AAL_OP_AND_ACC: accum_d = and_mem;
                // RULE3: AND immediate in
                `AAL_OP_AND_IMM: accum_d = and_imm;
                // RULE1: accumulator left alone
                default:         accum_d = accum_q;
            endcase
        end else if (wr_done & hit_accu) begin
            accum_d = pwdata[7:0];
        end
    end

    // Next flags: only the listed ones move, the rest hold
    always @* begin
        flags_d = flags_q;
        if (go) begin
            // RULE5: zero from result
            flags_d[`AAL_F_ZERO] = (res == 8'h00);
            // RULE1: add updates carries
            if (op == `AAL_OP_ADD_MEM) begin
                flags_d[`AAL_F_CARRY]  = sum[8];
                flags_d[`AAL_F_AUXC]   = lo_sum[4];
                flags_d[`AAL_F_OVFL]   = ovfl;
                flags_d[`AAL_F_SCARRY] = scarry;
            end
        end
    end

    // Next operand: immediate and memory index load together
    always @* begin
        imm_d = imm_q;
        idx_d = idx_q;
        if (wr_done & hit_opnd) begin
            imm_d = pwdata[`AAL_IMM_MSB:`AAL_IMM_LSB];
            idx_d = pwdata[`AAL_IDX_MSB:`AAL_IDX_LSB];
        end
    end

    // Core state registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accum_q <= `AAL_ACCU_RST;
            flags_q <= `AAL_FLAGS_RST;
            imm_q   <= `AAL_IMM_RST;
            idx_q   <= `AAL_IDX_RST;
        end else begin
            accum_q <= accum_d;
            flags_q <= flags_d;
            imm_q   <= imm_d;
            idx_q   <= idx_d;
        end
    end

    // Data memory: result write-back first, then bus writes
    always @(posedge pclk) begin
        // RULE1: sum to memory
        // RULE4: AND to memory
        if (mem_wb) begin
            mem_q[idx_q] <= res;
        end else if (wr_done & hit_mem) begin
            mem_q[mem_idx] <= pwdata[7:0];
        end
    end

    // Read data chosen during setup, shown in the access cycle
    always @* begin
        prdata_d = `AAL_RDATA_RST;
        if (rd_setup) begin
            if (hit_mem) begin
                prdata_d = {24'h00_0000, mem_q[mem_idx]};
            end else if (hit_opnd) begin
                prdata_d = {16'h0000, 2'b00, idx_q, imm_q};
            end else if (hit_accu) begin
                prdata_d = {24'h00_0000, accum_q};
            end else if (hit_stat) begin
                prdata_d = {24'h00_0000, 3'b000, flags_q};
            end
        end
    end

    // Bus answer: ready one cycle after setup, no wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= `AAL_RDATA_RST;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q  <= prdata_d;
        end
    end

    // Outputs straight from their flip-flops
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign accumulator = accum_q;
endmodule
`default_nettype wire

// ### acc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module aal_checker (input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire [11:0] paddr, input wire [31:0] pwdata, input wire [7:0] accumulator, input wire [4:0] flags_q);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Opcode write completing, and its two AND-into-accumulator kinds
    wire g = psel & penable & pready & pwrite & paddr == 0, n = g & ^pwdata[1:0];
    wire [1:0] o = pwdata[1:0];
    a_add_acc: assert property (g && o == 0 |=> $stable(accumulator)) else $error("acc moved");
    a_and_bits: assert property (n |=> !(accumulator & ~$past(accumulator))) else $error("bit set");
    a_and_zero: assert property (n |=> flags_q[2] == !accumulator) else $error("zero flag");
    a_and_into_memory_op_acc: assert property (g && o == 3 |=> $stable(accumulator)) else $error("acc moved");
    a_keep_flags: assert property (g && o |=> $stable(flags_q & 5'h1b)) else $error("flag moved");
    c_add: cover property (g && !o); c_and: cover property (n); c_err: cover property (pslverr);
endmodule
bind aal_alu aal_checker chk_u (.*);
`default_nettype wire

// ### acc_host.sv
`timescale 1ns/1ps
`default_nettype none
module aal_host (input wire pclk, pready, pslverr, input wire [31:0] prdata,
    output logic psel, penable, pwrite, output logic [11:0] paddr, output logic [31:0] pwdata);
    initial {psel, penable, pwrite, paddr, pwdata} = 0;
    // Setup cycle, access held until pready, then release
    task automatic xfer(input w, input [11:0] a, input [31:0] d, output [32:0] r);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (!pready);
        r = {pslverr, prdata}; {psel, penable} <= 0;
    endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr;
    logic [31:0] pwdata, prdata; logic [11:0] paddr; logic [32:0] r;
    logic [7:0] accumulator, a, m, x, s; logic [5:0] i; logic [4:0] flags_q, f = 0;
    int n_fail = 0, cmp_count = 0, o;
    always #5 pclk = ~pclk;
    aal_alu dut_u (.*); aal_host host_u (.*);
    // Expected flags and result of one operation, from the rules
    function automatic [12:0] model_op(input [1:0] op, input [7:0] a, input [7:0] m,
                                       input [7:0] x, input [4:0] fl);
        logic [8:0] t;
        logic       v;
        logic [7:0] s;
        logic [4:0] f;
        t = {1'b0, a} + {1'b0, m};
        v = (a[7] == m[7]) && (t[7] != a[7]);
        s = (op == 2'h2) ? (a & x) : (op != 2'h0) ? (a & m) : t[7:0];
        f = fl;
        if (op == 2'h0) f = {v ^ t[7], v, 1'b0, ({1'b0, a[3:0]} + {1'b0, m[3:0]}) > 5'h0F, t[8]};
        f[2] = (s == 8'h00);
        model_op = {f, s};
    endfunction
    // Count one compare, report a mismatch with both values
    task check(input [32:0] seen, input [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin n_fail++; $display("[FAIL] %0t %h %h", $time, seen, exp); end
    endtask
    task end_sim;
        $display("%0d compares %0d fails", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Read a word and compare it with the expected one
    task rc(input [11:0] ad, input [32:0] e);
        host_u.xfer(0, ad, 0, r);
        check(r, e);
    endtask
    initial begin #99000 n_fail++; end_sim; end
    // Reset, corner operands first, then random ones
    initial begin
        i = $urandom(23); repeat (3) @(posedge pclk); presetn <= 1;
        rc(12'h00c, 0); rc(12'h0f0, 33'h1_0000_0000);
        for (int k = 0; k < 40; k++) begin
            {a, m, x, i} = 30'($urandom); o = k % 4;
            if (k < 8) {a, m} = k < 4 ? 16'h8080 : {a, ~a};
            host_u.xfer(1, 12'h008, a, r); host_u.xfer(1, 12'h100 + {i, 2'b0}, m, r);
            host_u.xfer(1, 12'h004, {i, x}, r); host_u.xfer(1, 12'h000, o, r);
            {f, s} = model_op(o[1:0], a, m, x, f);
            rc(12'h00c, f); rc(12'h008, o % 3 ? s : a); rc(12'h100 + {i, 2'b0}, o % 3 ? m : s);
            check({28'h000_0000, flags_q}, {28'h000_0000, f});
            check({25'h000_0000, accumulator}, {25'h000_0000, o % 3 ? s : a});
            $display("test %0d done", k);
        end
        end_sim;
    end
endmodule
`default_nettype wire
